// [inc/rpd_pkg.sv]
// Purpose: Constants for the rotor position detector
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets are indices on the register port
package rpd_pkg;
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_CONFIG  = 2'h1;
  localparam logic [1:0] ADDR_STATUS  = 2'h2;
  localparam logic [1:0] ADDR_DELAY   = 2'h3;
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] CONFIG_RST   = 8'h00;
  localparam logic [7:0] DELAY_RST    = 8'h00;
  // detect_control fields
  localparam int CTL_SW_STOP   = 7;
  localparam int CTL_SW_START  = 6;
  localparam int CTL_TMR_STOP  = 5;
  localparam int CTL_TMR_START = 4;
  localparam int CTL_SINGLE    = 3;
  localparam int CTL_RECOUNT   = 2;
  localparam int CTL_DETMODE   = 1;
  localparam int CTL_ENABLE    = 0;
  // sampling_config fields
  localparam int CFG_CLK_HI  = 7;
  localparam int CFG_CLK_LO  = 6;
  localparam int CFG_MODE_HI = 5;
  localparam int CFG_MODE_LO = 4;
  localparam int CFG_CNT_HI  = 3;
  localparam int CFG_CNT_LO  = 0;
  // detect_result_status fields
  localparam int STA_EDGE_HI = 5;
  localparam int STA_EDGE_LO = 4;
  localparam int STA_ACTIVE  = 3;
  localparam int STA_SNAP_HI = 2;
  localparam int STA_SNAP_LO = 0;
  // Delay unit is two peripheral clocks
  localparam int DELAY_UNIT_CYC = 2;
  typedef enum logic [1:0] {
    RPD_MODE_PWM_ON,
    RPD_MODE_REGULAR,
    RPD_MODE_LOWER,
    RPD_MODE_RESERVED
  } rpd_smode_e;
endpackage : rpd_pkg

// [verilog/rpd_sync.sv]
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Pin level may change at any time
// Notes:   Output updates when stages two and three agree
module rpd_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire  [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end
endmodule : rpd_sync

// [verilog/rpd_detector.sv]
// Purpose: Rotor position detection for a three-phase motor
// Assumes: PWM, lower-phase and timer triggers come from mclk logic
// Notes:   Position pins pass a three-stage synchroniser
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
module rpd_detector
  import rpd_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       u_phase_input,
  input  wire logic       v_phase_input,
  input  wire logic       w_phase_input,
  input  wire logic [2:0] expected_pattern,
  input  wire logic       pwm_on,
  input  wire logic [2:0] lower_on,
  input  wire logic       timer2_trigger,
  input  wire logic       timer3_trigger,
  output logic            position_detect_irq,
  output logic            sampling_active
);
  if (CNT_W != 4) begin : g_cnt_w_check
    $error("rpd_detector: CNT_W must be 4");
  end

  logic [7:0]       detect_control;
  logic [7:0]       sampling_config;
  logic [7:0]       sampling_delay;
  logic [1:0]       edge_result_field;
  logic [2:0]       start_snapshot_field;
  logic [CNT_W-1:0] match_count;
  logic [3:0]       prescale;
  logic [8:0]       delay_cnt;
  logic             delay_done;
  logic             seen_mismatch;
  logic             pwm_q;
  logic             found_on;
  logic             found_off;
  logic [2:0]       held_pos;
  logic [2:0]       pos_sync;
  logic [2:0]       lower_q;
  logic [8:0]       lower_cnt [3];
  logic [2:0]       lower_done;

  // Synchronised position pins
  rpd_sync #(.WIDTH(3)) u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pin   ({w_phase_input, v_phase_input, u_phase_input}),
    .level (pos_sync)
  );

  // Register decode
  wire wr_ctl   = reg_wr && (reg_addr == ADDR_CONTROL);
  wire wr_cfg   = reg_wr && (reg_addr == ADDR_CONFIG);
  wire wr_delay = reg_wr && (reg_addr == ADDR_DELAY);

  // Control fields
  wire        func_en     = detect_control[CTL_ENABLE];
  wire        change_mode = detect_control[CTL_DETMODE];
  wire        recount_bit = detect_control[CTL_RECOUNT];
  wire        single_in   = detect_control[CTL_SINGLE];
  wire [1:0]  clk_sel     = sampling_config[CFG_CLK_HI:CFG_CLK_LO];
  wire [1:0]  smode_raw   = sampling_config[CFG_MODE_HI:CFG_MODE_LO];
  wire [3:0]  cnt_raw     = sampling_config[CFG_CNT_HI:CFG_CNT_LO];
  rpd_smode_e smode;
  assign smode = rpd_smode_e'(smode_raw);

  // Starts and stops
  wire sw_start = wr_ctl && reg_wdata[CTL_SW_START];
  wire sw_stop  = wr_ctl && reg_wdata[CTL_SW_STOP];
  wire tm_start = timer2_trigger && detect_control[CTL_TMR_START];
  wire tm_stop  = timer3_trigger && detect_control[CTL_TMR_STOP];
  wire en_now    = wr_ctl ? reg_wdata[CTL_ENABLE] : func_en;
  wire start_req = en_now && (sw_start || tm_start);
  wire stop_req  = sw_stop || tm_stop || !en_now;

  // Count 0 treated as 1
  wire [CNT_W-1:0] target =
    (cnt_raw == 4'h0) ? CNT_W'(1) : cnt_raw;

  // Sampling period tick
  function automatic logic tick_of(input logic [1:0] sel,
                                   input logic [3:0] pre);
    case (sel)
      2'h0:    tick_of = pre[0] == 1'b1;
      2'h1:    tick_of = pre[1:0] == 2'h3;
      2'h2:    tick_of = pre[2:0] == 3'h7;
      default: tick_of = pre == 4'hF;
    endcase
  endfunction
  wire tick = tick_of(clk_sel, prescale);

  // Delay after PWM turn-on
  wire pwm_rise = pwm_on && !pwm_q;
  wire pwm_fall = !pwm_on && pwm_q;
  wire [8:0] delay_target =
    9'(sampling_delay) * 9'(DELAY_UNIT_CYC);
  wire [2:0] lower_rise = lower_on & ~lower_q;

  // Delay reached once the count meets the target
  function automatic logic delay_reached(input logic [8:0] cnt,
                                         input logic [8:0] lim);
    delay_reached = (cnt + 9'h001) >= lim;
  endfunction

  logic next_delay_done;
  always_comb begin
    if (pwm_rise) begin
      next_delay_done = delay_target == 9'h000;
    end else begin
      next_delay_done = delay_done || delay_reached(delay_cnt, delay_target);
    end
  end
  wire [3:0] next_prescale  = start_req ? 4'h0 : prescale + 4'h1;
  wire [8:0] next_delay_cnt =
    pwm_rise ? 9'h000 : delay_cnt + 9'(!delay_done);

  // Per-phase sampling windows
  logic [2:0] phase_gate;
  always_comb begin
    case (smode)
      RPD_MODE_PWM_ON:
        phase_gate = {3{pwm_on && pwm_q && delay_done}};
      RPD_MODE_REGULAR: phase_gate = 3'h7;
      RPD_MODE_LOWER:   phase_gate = lower_on & lower_q & lower_done;
      default:          phase_gate = 3'h0;
    endcase
  end

  // Held input per phase: lower mode keeps last sample
  wire [2:0] next_held = (phase_gate & pos_sync) | (~phase_gate & held_pos);
  wire       any_gate  = |phase_gate;
  wire       do_sample = sampling_active && tick && any_gate;

  // Compare mask for single input
  wire [2:0] cmp_mask  = single_in ? 3'h1 : 3'h7;
  wire [2:0] ref_val   = change_mode ? start_snapshot_field
                                     : expected_pattern;
  wire       equal     = ((next_held ^ ref_val) & cmp_mask) == 3'h0;
  wire       hit       = change_mode ? !equal
                                     : (equal && seen_mismatch);
  wire       miss_seen = !change_mode && !equal;

  wire count_full = do_sample && hit && (match_count + CNT_W'(1) >= target);
  wire detect     = count_full;

  // Match counter next value
  logic [CNT_W-1:0] next_count;
  always_comb begin
    if (start_req || detect) begin
      next_count = '0;
    end else if (recount_bit && pwm_fall && smode != RPD_MODE_REGULAR) begin
      next_count = '0;
    end else if (!do_sample) begin
      next_count = match_count;
    end else if (hit) begin
      next_count = match_count + CNT_W'(1);
    end else begin
      next_count = '0;
    end
  end

  // Edge result: bit 1 falling side, bit 0 rising side
  wire [1:0] next_edge = {found_off, found_on};

  // Status and read data
  wire [7:0] status_word = {2'h0, edge_result_field, sampling_active,
                            start_snapshot_field};
  wire [7:0] ctl_readback = {2'h0, detect_control[5:0]};
  logic [7:0] next_rdata;
  always_comb begin
    case (reg_addr)
      ADDR_CONTROL: next_rdata = ctl_readback;
      ADDR_CONFIG:  next_rdata = sampling_config;
      ADDR_STATUS:  next_rdata = status_word;
      default:      next_rdata = sampling_delay;
    endcase
  end

  // Register file
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      detect_control  <= CONTROL_RST;
      sampling_config <= CONFIG_RST;
      sampling_delay  <= DELAY_RST;
    end else begin
      if (wr_ctl) begin
        detect_control <= {2'h0, reg_wdata[5:0]};
      end
      if (wr_cfg) begin
        sampling_config <= reg_wdata;
      end
      if (wr_delay) begin
        sampling_delay <= reg_wdata;
      end
    end
  end

  // Read data, zero outside the answer cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // PWM edge, prescaler and turn-on delay
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_q      <= 1'b0;
      prescale   <= 4'h0;
      delay_cnt  <= 9'h000;
      delay_done <= 1'b0;
    end else begin
      pwm_q      <= pwm_on;
      prescale   <= next_prescale;
      delay_cnt  <= next_delay_cnt;
      delay_done <= next_delay_done;
    end
  end

  // Lower-phase delay, one counter per phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lower_q    <= 3'h0;
      lower_done <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        lower_cnt[i] <= 9'h000;
      end
    end else begin
      lower_q <= lower_on;
      for (int i = 0; i < 3; i++) begin
        if (lower_rise[i]) begin
          lower_cnt[i]  <= 9'h000;
          lower_done[i] <= delay_target == 9'h000;
        end else if (!lower_done[i]) begin
          lower_cnt[i]  <= lower_cnt[i] + 9'h001;
          lower_done[i] <= delay_reached(lower_cnt[i], delay_target);
        end
      end
    end
  end

  // Sampling state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sampling_active <= 1'b0;
    end else if (detect || stop_req) begin
      sampling_active <= 1'b0;
    end else if (start_req) begin
      sampling_active <= 1'b1;
    end
  end

  // Snapshot, held inputs and match counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      start_snapshot_field <= 3'h0;
      held_pos             <= 3'h0;
      seen_mismatch        <= 1'b0;
      match_count          <= '0;
    end else begin
      if (start_req && change_mode) begin
        start_snapshot_field <= pos_sync;
      end
      if (start_req) begin
        held_pos      <= pos_sync;
        seen_mismatch <= 1'b0;
      end else begin
        held_pos      <= next_held;
        seen_mismatch <= seen_mismatch || (do_sample && miss_seen);
      end
      match_count   <= next_count;
    end
  end

  // Edge result
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      found_on          <= 1'b0;
      found_off         <= 1'b0;
      edge_result_field <= 2'h0;
    end else begin
      if (start_req || detect) begin
        found_on  <= 1'b0;
        found_off <= 1'b0;
      end else begin
        if (pwm_rise && sampling_active) begin
          found_on <= 1'b1;
        end
        if (pwm_fall && sampling_active) begin
          found_off <= 1'b1;
        end
      end
      if (detect) begin
        edge_result_field <= next_edge;
      end
    end
  end

  // Detection request pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      position_detect_irq <= 1'b0;
    end else begin
      position_detect_irq <= detect;
    end
  end
endmodule : rpd_detector

// [verif/rpd_detector_chk.sv]
// Purpose: Port assertions for the position detector
// Assumes: Control and config shadowed from the write port
// Notes:   Bound to rpd_detector from the bench top file
module rpd_detector_chk
  import rpd_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       timer2_trigger,
  input wire logic       timer3_trigger,
  input wire logic       position_detect_irq,
  input wire logic       sampling_active
);
  logic [7:0] ctl;
  logic [7:0] cfg;
  wire        wr_ctl = reg_wr && (reg_addr == ADDR_CONTROL);
  wire        wr_cfg = reg_wr && (reg_addr == ADDR_CONFIG);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl <= CONTROL_RST;
      cfg <= CONFIG_RST;
    end else begin
      if (wr_ctl) ctl <= reg_wdata;
      if (wr_cfg) cfg <= reg_wdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_start;
    wr_ctl && reg_wdata[CTL_SW_START] && reg_wdata[CTL_ENABLE]
      && !reg_wdata[CTL_SW_STOP];
  endsequence
  sequence s_stop;
    wr_ctl && !reg_wdata[CTL_SW_START]
      && (reg_wdata[CTL_SW_STOP] || !reg_wdata[CTL_ENABLE]);
  endsequence
  sequence s_det;
    position_detect_irq;
  endsequence
  AST_IRQ_PULSE: assert property (s_det |=> !position_detect_irq)
    else $error("detect pulse longer than one cycle");
  AST_IRQ_ENDS: assert property (s_det |-> !sampling_active)
    else $error("sampling still active at detection");
  AST_IRQ_CAUSE: assert property (s_det |-> $past(sampling_active)
    && $past(ctl[CTL_ENABLE])) else $error("detection while not sampling");
  AST_NO_RSVD: assert property (s_det |->
    $past(cfg[CFG_MODE_HI:CFG_MODE_LO]) != 2'h3)
    else $error("detection in reserved mode");
  AST_START: assert property (s_start && !sampling_active
    |=> sampling_active)
    else $error("start did not begin sampling");
  AST_STOP: assert property (s_stop |=> !sampling_active)
    else $error("stop did not end sampling");
  AST_TMR_START: assert property (timer2_trigger && !reg_wr
    && !sampling_active && ctl[CTL_TMR_START] && ctl[CTL_ENABLE]
    |-> ##[1:2] sampling_active) else $error("timer start ignored");
  AST_TMR_STOP: assert property (timer3_trigger && !reg_wr
    && !timer2_trigger && ctl[CTL_TMR_STOP]
    |-> ##[1:2] !sampling_active) else $error("timer stop ignored");
  AST_STATUS: assert property (reg_rd && reg_addr == ADDR_STATUS
    |=> reg_rdata[STA_ACTIVE] == $past(sampling_active))
    else $error("status bit differs from sampling state");
  AST_CTL_RD: assert property (reg_rd && reg_addr == ADDR_CONTROL
    |=> reg_rdata == {2'h0, $past(ctl[5:0])})
    else $error("control readback wrong");
endmodule // rpd_detector_chk

// [verif/rpd_pin_model.sv]
// Purpose: Hall or comparator model on the position pins
// Assumes: Pins follow the requested pattern, unrelated to mclk
// Notes:   Settles 3 ns after the target moves
module rpd_pin_model (
  input  wire logic [2:0] target,
  output wire logic       u_phase_input,
  output wire logic       v_phase_input,
  output wire logic       w_phase_input
);
  timeunit 1ns;
  timeprecision 100ps;
  assign #3 {w_phase_input, v_phase_input, u_phase_input} = target;
endmodule // rpd_pin_model

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the position detector
// Assumes: Random configurations from a fixed seed
// Notes:   Position pins come from rpd_pin_model
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rpd_pkg::*;
  logic       mclk, rst_b, reg_wr, reg_rd, pwm, t2, t3;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, q;
  logic [2:0] exp_pat, tgt, lo;
  logic       irq, act;
  wire        pu, pv, pw;
  int         num_errors, total_checks;
  int         cnt0, fst0;
  rpd_detector u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .u_phase_input(pu), .v_phase_input(pv), .w_phase_input(pw),
    .expected_pattern(exp_pat), .pwm_on(pwm), .lower_on(lo),
    .timer2_trigger(t2), .timer3_trigger(t3),
    .position_detect_irq(irq), .sampling_active(act));
  rpd_pin_model u_pins (.target(tgt), .u_phase_input(pu),
    .v_phase_input(pv), .w_phase_input(pw));
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_wr, addr, wdata} <= {1'b1, a, d};
    @(posedge mclk);
    reg_wr <= 0;
    #1;
  endtask
  task rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    {reg_rd, addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 0;
    #1 d = rdata;
  endtask
  task pulse(input bit w);
    @(posedge mclk);
    {t3, t2} <= w ? 2'h2 : 2'h1;
    @(posedge mclk);
    {t3, t2} <= 2'h0;
    @(posedge mclk);
    #1;
  endtask
  task watch(input logic [2:0] p, input int len, output int cnt,
             output int fst);
    @(posedge mclk);
    tgt <= p;
    cnt = 0;
    fst = -1;
    for (int i = 0; i < len; i++) begin
      @(posedge mclk);
      #1;
      if (irq === 1'b1 && fst < 0) fst = i;
      if (irq === 1'b1) cnt++;
    end
  endtask
  function automatic logic [7:0] rcfg(input logic [1:0] m);
    logic [7:0] r;
    r = $urandom;
    return {r[7:6], m, r[3:0]};
  endfunction
  // Kind 0 mismatch then match, 1 change from start, 2 U pin only
  task scen(input logic [7:0] cfg, input logic [7:0] ctl, input int kind,
            input bit want);
    logic [2:0] ex, b, c;
    logic [7:0] dly, st;
    int cnt, fst, n, dv;
    ex = $urandom;
    dly = $urandom % 64;
    b = kind == 0 ? ~ex : (kind == 2 ? ex ^ 3'h1 : ex);
    c = kind == 1 ? ~ex : (kind == 2 ? ex ^ 3'h6 : ex);
    n = cfg[3:0] == 0 ? 1 : int'(cfg[3:0]);
    dv = 2 << cfg[7:6];
    @(posedge mclk);
    {exp_pat, tgt} <= {ex, ex};
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONFIG, cfg);
    wr(ADDR_DELAY, dly);
    rd(ADDR_CONFIG, st);
    chk(st, cfg);
    wr(ADDR_CONTROL, ctl);
    wr(ADDR_CONTROL, ctl | 8'h40);
    rd(ADDR_STATUS, st);
    chk(st[3], ctl[0]);
    if (ctl[1]) chk(st[2:0], ex);
    watch(ex, 300, cnt, fst);
    chk(8'(cnt), 8'h00);
    watch(b, 300, cnt, fst);
    chk(8'(cnt), 8'h00);
    watch(c, 400, cnt, fst);
    chk(8'(cnt), 8'(want));
    if (want) begin
      chk(8'(fst >= (n - 1) * dv && fst <= (n + 2) * dv + 12 + 2 * dly),
          8'h01);
      chk(act, 1'b0);
      rd(ADDR_STATUS, st);
      chk(st[5:4], 2'h0);
    end
    wr(ADDR_CONTROL, 8'h00);
  endtask
  initial begin
    {rst_b, reg_wr, reg_rd, pwm, t2, t3, addr, wdata} = '0;
    {exp_pat, tgt, lo} = '0;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(32'h844C));
    repeat (8) @(posedge mclk);
    rst_b <= 1;
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), q);
      chk(q, 8'h00);
    end
    wr(ADDR_CONTROL, 8'hFE);
    rd(ADDR_CONTROL, q);
    chk(q, 8'h3E);
    {pwm, lo} <= 4'hF;
    for (int m = 0; m < 4; m++)
      scen(rcfg(2'(m)), 8'h01, 0, m != 3);
    scen(rcfg(2'h1), 8'h03, 1, 1);
    scen(rcfg(2'h1), 8'h09, 2, 1);
    scen(rcfg(2'h1), 8'h00, 0, 0);
    scen(8'h10, 8'h01, 0, 1);
    pwm <= 0;
    scen(rcfg(2'h0), 8'h01, 0, 0);
    @(posedge mclk);
    tgt <= 3'h5;
    wr(ADDR_CONFIG, 8'h01);
    wr(ADDR_DELAY, 8'h14);
    wr(ADDR_CONTROL, 8'h03);
    wr(ADDR_CONTROL, 8'h43);
    rd(ADDR_STATUS, q);
    chk(q, 8'h0D);
    watch(3'h2, 40, cnt0, fst0);
    chk(8'(cnt0), 8'h00);
    @(posedge mclk);
    pwm <= 1;
    watch(3'h2, 60, cnt0, fst0);
    chk(8'(cnt0), 8'h01);
    chk(8'(fst0 >= 38 && fst0 <= 42), 8'h01);
    rd(ADDR_STATUS, q);
    chk(q, 8'h15);
    wr(ADDR_CONTROL, 8'h00);
    @(posedge mclk);
    {pwm, exp_pat, tgt} <= {1'b1, 3'h5, 3'h5};
    wr(ADDR_CONFIG, 8'h10);
    wr(ADDR_CONTROL, 8'h31);
    wr(ADDR_CONTROL, 8'h71);
    chk(act, 1'b1);
    wr(ADDR_CONTROL, 8'hB1);
    chk(act, 1'b0);
    pulse(0);
    chk(act, 1'b1);
    wr(ADDR_CONTROL, 8'h31);
    chk(act, 1'b1);
    pulse(1);
    chk(act, 1'b0);
    stop_test;
  end
  initial begin
    #300000;
    num_errors++;
    stop_test;
  end
endmodule // tb_top
bind rpd_detector rpd_detector_chk #(.CNT_W(CNT_W)) u_chk (.mclk(mclk),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timer2_trigger(timer2_trigger), .timer3_trigger(timer3_trigger),
  .position_detect_irq(position_detect_irq),
  .sampling_active(sampling_active));
